// ==== logic/gp_line_pkg.sv ====
package gp_line_pkg;

    // ***********************************************************
    // Register bus
    // ***********************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    localparam logic [ADDR_W-1:0] EVT_SET_OFS = 8'h80;
    localparam logic [ADDR_W-1:0] EVT_CLR_OFS = 8'h84;
    localparam logic [ADDR_W-1:0] MASK_SET_OFS = 8'h88;
    localparam logic [ADDR_W-1:0] MASK_CLR_OFS = 8'h8C;
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'hFC;

    // ***********************************************************
    // Line control register fields
    // ***********************************************************
    localparam int L3_IRQ_EN_BIT = 31;
    localparam int L3_INV_BIT = 29;
    localparam int L3_OE_BIT = 28;
    localparam int L3_VALUE_BIT = 24;
    localparam int L2_IRQ_EN_BIT = 23;
    localparam int L2_INV_BIT = 21;
    localparam int L2_OE_BIT = 20;
    localparam int L2_VALUE_BIT = 16;

    localparam logic [DATA_W-1:0] CTRL_USED_MASK = 32'hB1B1_0000;
    localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0000;

    // ***********************************************************
    // Event and mask registers
    // ***********************************************************
    localparam int GP_EVENT_BIT = 0;
    localparam logic [DATA_W-1:0] EVT_USED_MASK = 32'h0000_0001;
    localparam logic EVT_RST = 1'h0;
    localparam logic MASK_RST = 1'h0;

    // ***********************************************************
    // Line channel
    // ***********************************************************
    localparam int SYNC_STAGES = 2;
    localparam logic LINE_LEVEL_RST = 1'h0;

endpackage

// ==== logic/line_channel.sv ====
`timescale 1ns/10ps
`default_nettype none

module line_channel
    import gp_line_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic line_i,
    input wire logic invert,
    input wire logic drive_value,
    input wire logic drive_enable,
    output logic line_o,
    output logic line_oe_n,
    output logic level,
    output logic change
);

    logic meta_q;
    logic sync_q;
    logic prev_q;
    logic line_o_q;
    logic oe_n_q;

    // ***********************************************************
    // Input synchroniser and edge detect
    // ***********************************************************
    // First stage is read only by the second stage
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= LINE_LEVEL_RST;
            sync_q <= LINE_LEVEL_RST;
            prev_q <= LINE_LEVEL_RST;
        end
        else
        begin
            meta_q <= line_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // Compared on the raw sample so a polarity write alone raises no event while the line is released
    assign change = sync_q ^ prev_q;
    assign level = sync_q ^ invert;

    // ***********************************************************
    // Output drive
    // ***********************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            line_o_q <= 1'h0;
            oe_n_q <= 1'h1;
        end
        else
        begin
            line_o_q <= drive_value ^ invert;
            oe_n_q <= !drive_enable;
        end
    end

    assign line_o = line_o_q;
    assign line_oe_n = oe_n_q;

    // ***********************************************************
    // Checks
    // ***********************************************************
    a_pulse_one_edge: assert property (@(posedge clk) disable iff (!rst_n)
        change && meta_q == sync_q |=> !change)
        else $error("change pulse repeated for one transition");

    a_edge_gives_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        (meta_q != sync_q) |=> change)
        else $error("input transition produced no change pulse");

endmodule

`default_nettype wire

// ==== logic/gp_line_control.sv ====
// Local design decision: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

module gp_line_control
    import gp_line_pkg::*;
(
    input wire logic CLK,
    input wire logic NRST,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [DATA_W-1:0] RDATA,
    input wire logic LINE2_I,
    output logic LINE2_O,
    output logic LINE2_OE_N,
    input wire logic LINE3_I,
    output logic LINE3_O,
    output logic LINE3_OE_N,
    output logic IRQ
);

    logic l3_irq_en_q;
    logic l3_inv_q;
    logic l3_oe_q;
    logic l3_value_q;
    logic l2_irq_en_q;
    logic l2_inv_q;
    logic l2_oe_q;
    logic l2_value_q;

    logic event_q;
    logic event_d;
    logic mask_q;
    logic mask_d;

    logic l2_level;
    logic l2_change;
    logic l3_level;
    logic l3_change;
    logic gp_event;

    logic [DATA_W-1:0] ctrl_view;
    logic [DATA_W-1:0] rdata_d;
    logic [DATA_W-1:0] rdata_q;

    logic wr_ctrl;
    logic wr_evt_set;
    logic wr_evt_clr;
    logic wr_mask_set;
    logic wr_mask_clr;

    // ***********************************************************
    // Address decode
    // ***********************************************************
    assign wr_ctrl = WR && (ADDR == CTRL_OFS);
    assign wr_evt_set = WR && (ADDR == EVT_SET_OFS);
    assign wr_evt_clr = WR && (ADDR == EVT_CLR_OFS);
    assign wr_mask_set = WR && (ADDR == MASK_SET_OFS);
    assign wr_mask_clr = WR && (ADDR == MASK_CLR_OFS);

    // ***********************************************************
    // Line control register
    // ***********************************************************
    // Only the documented fields have storage, so reserved bits cannot latch
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            l3_irq_en_q <= CTRL_RST[L3_IRQ_EN_BIT];
            l3_inv_q <= CTRL_RST[L3_INV_BIT];
            l3_oe_q <= CTRL_RST[L3_OE_BIT];
            l3_value_q <= CTRL_RST[L3_VALUE_BIT];
            l2_irq_en_q <= CTRL_RST[L2_IRQ_EN_BIT];
            l2_inv_q <= CTRL_RST[L2_INV_BIT];
            l2_oe_q <= CTRL_RST[L2_OE_BIT];
            l2_value_q <= CTRL_RST[L2_VALUE_BIT];
        end
        else if (wr_ctrl)
        begin
            l3_irq_en_q <= WDATA[L3_IRQ_EN_BIT];
            l3_inv_q <= WDATA[L3_INV_BIT];
            l3_oe_q <= WDATA[L3_OE_BIT];
            l3_value_q <= WDATA[L3_VALUE_BIT];
            l2_irq_en_q <= WDATA[L2_IRQ_EN_BIT];
            l2_inv_q <= WDATA[L2_INV_BIT];
            l2_oe_q <= WDATA[L2_OE_BIT];
            l2_value_q <= WDATA[L2_VALUE_BIT];
        end
    end

    // ***********************************************************
    // Line channels
    // ***********************************************************
    // Lines run to on-chip logic, so no pad cell sits behind these ports
    line_channel u_line2
    (
        .clk(CLK),
        .rst_n(NRST),
        .line_i(LINE2_I),
        .invert(l2_inv_q),
        .drive_value(l2_value_q),
        .drive_enable(l2_oe_q),
        .line_o(LINE2_O),
        .line_oe_n(LINE2_OE_N),
        .level(l2_level),
        .change(l2_change)
    );

    line_channel u_line3
    (
        .clk(CLK),
        .rst_n(NRST),
        .line_i(LINE3_I),
        .invert(l3_inv_q),
        .drive_value(l3_value_q),
        .drive_enable(l3_oe_q),
        .line_o(LINE3_O),
        .line_oe_n(LINE3_OE_N),
        .level(l3_level),
        .change(l3_change)
    );

    // ***********************************************************
    // Event and mask
    // ***********************************************************
    assign gp_event = (l3_change && l3_irq_en_q) || (l2_change && l2_irq_en_q);

    // A new event wins over a clear written in the same cycle
    always_comb
    begin
        event_d = event_q;
        if (wr_evt_clr && WDATA[GP_EVENT_BIT])
        begin
            event_d = 1'h0;
        end
        if (wr_evt_set && WDATA[GP_EVENT_BIT])
        begin
            event_d = 1'h1;
        end
        if (gp_event)
        begin
            event_d = 1'h1;
        end
    end

    always_comb
    begin
        mask_d = mask_q;
        if (wr_mask_set && WDATA[GP_EVENT_BIT])
        begin
            mask_d = 1'h1;
        end
        else if (wr_mask_clr && WDATA[GP_EVENT_BIT])
        begin
            mask_d = 1'h0;
        end
    end

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            event_q <= EVT_RST;
        end
        else
        begin
            event_q <= event_d;
        end
    end

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            mask_q <= MASK_RST;
        end
        else
        begin
            mask_q <= mask_d;
        end
    end

    assign IRQ = event_q && mask_q;

    // ***********************************************************
    // Read path
    // ***********************************************************
    always_comb
    begin
        ctrl_view = '0;
        ctrl_view[L3_IRQ_EN_BIT] = l3_irq_en_q;
        ctrl_view[L3_INV_BIT] = l3_inv_q;
        ctrl_view[L3_OE_BIT] = l3_oe_q;
        ctrl_view[L3_VALUE_BIT] = l3_level;
        ctrl_view[L2_IRQ_EN_BIT] = l2_irq_en_q;
        ctrl_view[L2_INV_BIT] = l2_inv_q;
        ctrl_view[L2_OE_BIT] = l2_oe_q;
        ctrl_view[L2_VALUE_BIT] = l2_level;
    end

    // Clear address reads the masked view, set address the raw event
    always_comb
    begin
        rdata_d = '0;
        case (ADDR)
            CTRL_OFS: rdata_d = ctrl_view;
            EVT_SET_OFS: rdata_d[GP_EVENT_BIT] = event_q;
            EVT_CLR_OFS: rdata_d[GP_EVENT_BIT] = event_q && mask_q;
            MASK_SET_OFS: rdata_d[GP_EVENT_BIT] = mask_q;
            MASK_CLR_OFS: rdata_d[GP_EVENT_BIT] = mask_q;
            default: rdata_d = '0;
        endcase
    end

    // Data stand only in the cycle after the strobe
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            rdata_q <= '0;
        end
        else if (RD)
        begin
            rdata_q <= rdata_d;
        end
        else
        begin
            rdata_q <= '0;
        end
    end

    assign RDATA = rdata_q;

    // ***********************************************************
    // Checks
    // ***********************************************************
    default clocking cb @(posedge CLK);
    endclocking

    default disable iff (!NRST);

    a_line3_event_set: assert property (
        l3_change && l3_irq_en_q |=> event_q)
        else $error("line three edge did not set the event");

    a_line2_event_set: assert property (
        l2_change && l2_irq_en_q |=> event_q)
        else $error("line two edge did not set the event");

    a_event_quiet: assert property (
        !event_q && !l3_irq_en_q && !l2_irq_en_q && !WR |=> !event_q)
        else $error("event set with both change enables off");

    a_irq_masked: assert property (
        !mask_q || !event_q |-> !IRQ)
        else $error("interrupt raised while masked or idle");

    a_irq_unmasked: assert property (
        event_q && mask_q && !WR |=> IRQ)
        else $error("unmasked event did not hold the interrupt");

    a_line3_drive: assert property (
        l3_oe_q && $stable(l3_oe_q) |=> LINE3_O == ($past(l3_value_q) ^ $past(l3_inv_q)))
        else $error("line three drive value wrong");

    a_polarity_out: assert property (
        $rose(l2_inv_q) && $stable(l2_value_q) |=> LINE2_O != $past(LINE2_O))
        else $error("line two polarity change not seen on output");

    a_float_disabled: assert property (
        !l3_oe_q && !l2_oe_q |=> LINE3_OE_N && LINE2_OE_N)
        else $error("line driven while its enable is clear");

    a_readback_live: assert property (
        RD && ADDR == CTRL_OFS |=> RDATA[L3_VALUE_BIT] == $past(l3_level)
            && RDATA[L2_VALUE_BIT] == $past(l2_level))
        else $error("value bits did not return the input level");

    a_reserved_zero: assert property (
        RD && ADDR == CTRL_OFS |=> (RDATA & ~CTRL_USED_MASK) == '0)
        else $error("reserved control bits read nonzero");

    a_read_one_cycle: assert property (
        !RD |=> RDATA == '0)
        else $error("read data stood outside its cycle");

    a_invert_sense: assert property (
        $stable(l3_inv_q) && $changed(l3_level) |-> l3_change)
        else $error("inverted level moved without a change pulse");

    a_soft_set: assert property (
        wr_evt_set && WDATA[GP_EVENT_BIT] |=> event_q)
        else $error("event set write did not set the event");

    a_event_clear: assert property (
        wr_evt_clr && WDATA[GP_EVENT_BIT] && !gp_event |=> !event_q)
        else $error("event clear write did not clear the event");

    a_mask_set: assert property (
        wr_mask_set && WDATA[GP_EVENT_BIT] |=> mask_q)
        else $error("mask set write did not set the mask");

    a_mask_clear: assert property (
        wr_mask_clr && WDATA[GP_EVENT_BIT] |=> !mask_q)
        else $error("mask clear write did not clear the mask");

    a_line2_enabled: assert property (
        l2_oe_q |=> !LINE2_OE_N)
        else $error("line two released while its enable is set");

    a_line3_enabled: assert property (
        l3_oe_q |=> !LINE3_OE_N)
        else $error("line three released while its enable is set");

    a_unmapped_zero: assert property (
        RD && ADDR != CTRL_OFS && ADDR != EVT_SET_OFS && ADDR != EVT_CLR_OFS
            && ADDR != MASK_SET_OFS && ADDR != MASK_CLR_OFS |=> RDATA == '0)
        else $error("unmapped address read nonzero");

    c_line3_irq: cover property (
        l3_irq_en_q && l3_change ##1 event_q && mask_q);

    c_clear_race: cover property (
        wr_evt_clr && WDATA[GP_EVENT_BIT] && gp_event);

    c_drive_and_read: cover property (
        l2_oe_q && RD && ADDR == CTRL_OFS);

    c_soft_set: cover property (
        wr_evt_set && WDATA[GP_EVENT_BIT] ##1 event_q);

    c_line2_irq: cover property (
        l2_irq_en_q && l2_change ##1 event_q && mask_q);

endmodule

`default_nettype wire

// ==== tb/gp_line_far_end.sv ====
`timescale 1ns/10ps
`default_nettype none

// ***********************************************************
// On-chip lines seen from the far side
// ***********************************************************
module gp_line_far_end
(
    input wire logic line2_o,
    input wire logic line2_oe_n,
    input wire logic line3_o,
    input wire logic line3_oe_n,
    input wire logic far2,
    input wire logic far3,
    output logic line2_i,
    output logic line3_i
);
    // The far side only drives a line that the block has released
    assign line2_i = line2_oe_n ? far2 : line2_o;
    assign line3_i = line3_oe_n ? far3 : line3_o;
endmodule

`default_nettype wire

// ==== tb/internal_gpio_pair_control_bench.sv ====
`timescale 1ns/10ps
`default_nettype none

module internal_gpio_pair_control_bench
    import gp_line_pkg::*;
;
    logic CLK = 1'h0;
    logic NRST = 1'h0;
    logic [ADDR_W-1:0] ADDR = 8'h00;
    logic [DATA_W-1:0] WDATA = 32'h0000_0000;
    logic WR = 1'h0;
    logic RD = 1'h0;
    logic [DATA_W-1:0] RDATA;
    logic LINE2_I, LINE2_O, LINE2_OE_N, LINE3_I, LINE3_O, LINE3_OE_N, IRQ;
    logic far2 = 1'h0;
    logic far3 = 1'h0;
    logic rd_seen = 1'h0;
    logic [31:0] seed_q = 32'h0000_0027;
    logic [DATA_W-1:0] exp_q[$];
    int n_fail = 0;
    int n_compared = 0;

    always #2.5 CLK = ~CLK;

    gp_line_control dut_u (.CLK(CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .LINE2_I(LINE2_I), .LINE2_O(LINE2_O),
        .LINE2_OE_N(LINE2_OE_N), .LINE3_I(LINE3_I), .LINE3_O(LINE3_O),
        .LINE3_OE_N(LINE3_OE_N), .IRQ(IRQ));

    gp_line_far_end far_u (.line2_o(LINE2_O), .line2_oe_n(LINE2_OE_N),
        .line3_o(LINE3_O), .line3_oe_n(LINE3_OE_N), .far2(far2), .far3(far3),
        .line2_i(LINE2_I), .line3_i(LINE3_I));

    // ***********************************************************
    // Helpers
    // ***********************************************************
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic check_word(input string name, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic check_bit(input string name, input logic e, input logic g);
        check_word(name, {31'h0, e}, {31'h0, g});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        WR <= 1'h1;
        ADDR <= a;
        WDATA <= d;
        @(posedge CLK);
        WR <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        @(posedge CLK);
        RD <= 1'h1;
        ADDR <= a;
        @(posedge CLK);
        RD <= 1'h0;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask

    task automatic report_and_stop;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ***********************************************************
    // Read data monitor
    // ***********************************************************
    // Read data stand for one cycle only, so they are taken mid-cycle
    always @(posedge CLK) rd_seen <= RD;
    always @(negedge CLK)
    begin
        if (rd_seen)
            check_word("read data", exp_q.pop_front(), RDATA);
    end

    initial
    begin
        #200us;
        n_fail++;
        report_and_stop();
    end

    // ***********************************************************
    // Main sequence
    // ***********************************************************
    initial
    begin
        logic [31:0] w, e;
        logic i2, i3, b2, b3;
        repeat (4) @(posedge CLK);
        NRST <= 1'h1;
        idle(1);
        check_bit("line2 enable", 1'h1, LINE2_OE_N);
        check_bit("line3 enable", 1'h1, LINE3_OE_N);
        rd(CTRL_OFS, CTRL_RST);
        rd(EVT_SET_OFS, 32'h0000_0000);
        rd(MASK_SET_OFS, 32'h0000_0000);
        wr(8'h40, 32'hFFFF_FFFF);
        rd(8'h40, 32'h0000_0000);
        // Random control words with reserved bits set too
        for (int k = 0; k < 12; k++)
        begin
            seed_q = xs(seed_q);
            w = seed_q;
            far2 <= w[0];
            far3 <= w[1];
            wr(CTRL_OFS, w);
            idle(5);
            i2 = w[L2_INV_BIT];
            i3 = w[L3_INV_BIT];
            b2 = (w[L2_OE_BIT] ? w[L2_VALUE_BIT] ^ i2 : w[0]) ^ i2;
            b3 = (w[L3_OE_BIT] ? w[L3_VALUE_BIT] ^ i3 : w[1]) ^ i3;
            e = w & CTRL_USED_MASK & 32'hFEFE_FFFF;
            e = e | {7'h0, b3, 7'h0, b2, 16'h0000};
            check_bit("line2 enable", ~w[L2_OE_BIT], LINE2_OE_N);
            check_bit("line3 enable", ~w[L3_OE_BIT], LINE3_OE_N);
            if (w[L2_OE_BIT])
                check_bit("line2 drive", w[L2_VALUE_BIT] ^ i2, LINE2_O);
            if (w[L3_OE_BIT])
                check_bit("line3 drive", w[L3_VALUE_BIT] ^ i3, LINE3_O);
            rd(CTRL_OFS, e);
        end
        // Change events through event and mask registers
        far2 <= 1'h0;
        far3 <= 1'h0;
        wr(CTRL_OFS, 32'h8000_0000);
        idle(5);
        wr(EVT_CLR_OFS, 32'h0000_0001);
        wr(MASK_SET_OFS, 32'h0000_0001);
        idle(3);
        check_bit("irq idle", 1'h0, IRQ);
        far3 <= 1'h1;
        idle(6);
        check_bit("irq line3 rise", 1'h1, IRQ);
        rd(EVT_CLR_OFS, 32'h0000_0001);
        wr(EVT_CLR_OFS, 32'h0000_0001);
        idle(4);
        check_bit("irq cleared", 1'h0, IRQ);
        rd(EVT_SET_OFS, 32'h0000_0000);
        wr(MASK_CLR_OFS, 32'h0000_0001);
        far3 <= 1'h0;
        idle(6);
        check_bit("irq masked", 1'h0, IRQ);
        rd(EVT_SET_OFS, 32'h0000_0001);
        rd(EVT_CLR_OFS, 32'h0000_0000);
        wr(EVT_CLR_OFS, 32'h0000_0001);
        far2 <= 1'h1;
        idle(6);
        rd(EVT_SET_OFS, 32'h0000_0000);
        // Software set path of the event bit
        wr(EVT_SET_OFS, 32'h0000_0001);
        rd(EVT_SET_OFS, 32'h0000_0001);
        wr(EVT_CLR_OFS, 32'h0000_0001);
        wr(CTRL_OFS, 32'h0080_0000);
        wr(MASK_SET_OFS, 32'h0000_0001);
        far2 <= 1'h0;
        idle(6);
        check_bit("irq line2 fall", 1'h1, IRQ);
        rd(MASK_CLR_OFS, 32'h0000_0001);
        idle(3);
        // Reset in mid-run must drop a pending interrupt and the mask
        NRST <= 1'h0;
        idle(2);
        check_bit("irq reset", 1'h0, IRQ);
        NRST <= 1'h1;
        idle(1);
        rd(MASK_SET_OFS, 32'h0000_0000);
        rd(EVT_SET_OFS, 32'h0000_0000);
        rd(CTRL_OFS, CTRL_RST);
        idle(3);
        report_and_stop();
    end
endmodule

`default_nettype wire
